// File: core/line_serdes.sv
// Ten-bit serializer and deserializer with bit-slip word boundary
`timescale 1ns/1ns
`default_nettype none
module line_serdes
  import pcs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Line bit timing and data
  input wire logic bit_tick,
  input wire logic rx_bit,
  input wire logic slip,
  // Symbol streams
  pcs_stream_if.snk tx,
  pcs_stream_if.src rx,
  // Line output and events
  output logic tx_bit,
  output logic underrun
);
  logic [3:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
  sym_t tsh_q, tsh_d, rsh_q, rsh_d, rword_q, rword_d;
  logic tbit_q, tbit_d, rv_q, rv_d, slip_q, slip_d, und_q, und_d;
  logic last;

  // Next symbol is taken on the tick that sends the last bit
  assign last = (tcnt_q == `SYM_LAST);
  assign tx.ready = bit_tick & last;
  assign rx.valid = rv_q;
  assign rx.data = rword_q;
  assign tx_bit = tbit_q;
  assign underrun = und_q;

  // Transmit shifter, bit 0 first; zeros fill a missing symbol
  always_comb begin
    tcnt_d = tcnt_q;
    tsh_d = tsh_q;
    tbit_d = tbit_q;
    und_d = 1'b0;
    if (bit_tick) begin
      tbit_d = tsh_q[0];
      tsh_d = {1'b0, tsh_q[9:1]};
      tcnt_d = tcnt_q + 4'h1;
      if (last) begin
        tcnt_d = 4'h0;
        tsh_d = tx.valid ? tx.data : 10'h000;
        und_d = ~tx.valid;
      end
    end
  end

  // Receive shifter; a slip holds the count for one bit
  always_comb begin
    rcnt_d = rcnt_q;
    rsh_d = rsh_q;
    rword_d = rword_q;
    rv_d = 1'b0;
    slip_d = slip_q | slip;
    if (bit_tick) begin
      rsh_d = {rx_bit, rsh_q[9:1]};
      if (slip_q) begin
        slip_d = slip;
      end else if (rcnt_q == `SYM_LAST) begin
        rcnt_d = 4'h0;
        rv_d = 1'b1;
        rword_d = {rx_bit, rsh_q[9:1]};
      end else begin
        rcnt_d = rcnt_q + 4'h1;
      end
    end
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tcnt_q <= 4'h0;
      tsh_q <= 10'h000;
      tbit_q <= 1'b0;
      und_q <= 1'b0;
      rcnt_q <= 4'h0;
      rsh_q <= 10'h000;
      rword_q <= 10'h000;
      rv_q <= 1'b0;
      slip_q <= 1'b0;
    end else begin
      tcnt_q <= tcnt_d;
      tsh_q <= tsh_d;
      tbit_q <= tbit_d;
      und_q <= und_d;
      rcnt_q <= rcnt_d;
      rsh_q <= rsh_d;
      rword_q <= rword_d;
      rv_q <= rv_d;
      slip_q <= slip_d;
    end
  end
endmodule
`default_nettype wire

// File: core/pcs_map.svh
// Register offsets, field positions and counts for the channel datapath
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH
// Notes on behaviour
// - Narrow video words go through one phase buffer and the 10:1 shifter.
// - Wide video words are also split in two by a byte serializer first.
// - Video transmit only converts; scrambling and CRC come from the fabric.
// - Narrow video receive is recovery, 1:10 shifter, bit slip and a buffer.
// - Wide video receive also pairs two symbols into one word.
// - Fixed-latency mode turns both phase buffers into plain registers.
// - A phase buffer in register mode adds exactly one cycle of latency.
// - Narrow fixed-latency mode is 8 bits coded or 10 bits uncoded.
// - Wide fixed-latency mode is 16 bits coded or 20 bits uncoded.
// - Fixed-latency mode enables the channel PLL feedback path.
// - The direct path carries raw 20-bit words; coding is done in fabric.
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_TXCNT 12'h008
`define OFS_RXCNT 12'h00C
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_DOUBLE 2
`define CTRL_CODING 3
`define CTRL_ENABLE 4
`define CTRL_RESET 5'h00
`define ST_UNDER 2
`define ST_OVER 3
`define SYM_LAST 4'h9
`endif

// File: core/pcs_pkg.sv
// Types shared by the channel datapath modules
`include "pcs_map.svh"
package pcs_pkg;
  typedef enum logic [1:0] {
    MODE_VIDEO = 2'h0,
    MODE_DETLAT = 2'h1,
    MODE_DIRECT = 2'h3,
    MODE_RSVD = 2'h2
  } chan_mode_e;
  typedef enum logic {
    HALF_LOW = 1'h0,
    HALF_HIGH = 1'h1
  } half_e;
  typedef logic [9:0] sym_t;
  typedef logic [19:0] word_t;
endpackage

// File: core/pcs_stream_if.sv
// Valid and ready stream between the datapath modules
`timescale 1ns/1ns
`default_nettype none
interface pcs_stream_if #(parameter int W = 20) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: core/serial_channel_protocol_datapath.sv
// Channel datapath top: APB registers, line sampling, byte serdes, buffers
`timescale 1ns/1ns
`default_nettype none
`include "pcs_map.svh"
module serial_channel_protocol_datapath
  import pcs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fabric transmit words
  input wire word_t tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Fabric receive words
  output word_t rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic rx_bitslip,
  // Line side
  input wire logic link_clk,
  input wire logic rx_serial,
  output logic tx_serial,
  // Channel PLL
  output logic pll_fb_en
);
  logic [4:0] ctrl_q, ctrl_d;
  logic [15:0] txcnt_q, txcnt_d, rxcnt_q, rxcnt_d;
  logic [7:0] slip_q, slip_d;
  logic under_q, under_d, over_q, over_d;
  logic run_q, run_d, regm_q, regm_d, pll_q, pll_d;
  logic [31:0] prdata_q, prdata_d, status;
  logic pready_q, pready_d, perr_q, perr_d;
  logic [1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
  logic bs_prev_q, slip_req, bit_tick, underrun, rx_over;
  logic acc, wr_done, dbl, cod, path_rst;
  chan_mode_e mode;
  half_e txh_q, txh_d, rxh_q, rxh_d;
  sym_t low_q, low_d;
  logic asm_v_q, asm_v_d;
  word_t asm_w_q, asm_w_d;

  // Legal mode and width combinations
  function automatic logic cfg_ok(input chan_mode_e m, input logic d,
                                  input logic c);
    case (m)
      MODE_VIDEO: cfg_ok = ~c;
      MODE_DETLAT: cfg_ok = 1'b1;
      MODE_DIRECT: cfg_ok = d & ~c;
      default: cfg_ok = 1'b0;
    endcase
  endfunction

  // Symbol for one half of a fabric word; coding keeps the byte only
  function automatic sym_t sym_of(input word_t w, input logic c,
                                  input logic hi);
    sym_t s;
    s = hi ? w[19:10] : w[9:0];
    if (c) begin
      s = hi ? {2'h0, w[15:8]} : {2'h0, w[7:0]};
    end
    sym_of = s;
  endfunction

  // Fabric word from one or two received symbols
  function automatic word_t word_of(input sym_t hi, input sym_t lo,
                                    input logic c, input logic d);
    word_t w;
    w = d ? {hi, lo} : {10'h000, lo};
    if (c) begin
      w = d ? {4'h0, hi[7:0], lo[7:0]} : {12'h000, lo[7:0]};
    end
    word_of = w;
  endfunction

  // Control fields and datapath reset while stopped
  assign mode = chan_mode_e'(ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO]);
  assign dbl = ctrl_q[`CTRL_DOUBLE];
  assign cod = ctrl_q[`CTRL_CODING];
  assign path_rst = srst | ~run_q;

  // Streams between the stages
  pcs_stream_if #(.W(20)) tx_fab ();
  pcs_stream_if #(.W(20)) tx_word ();
  pcs_stream_if #(.W(10)) tx_sym ();
  pcs_stream_if #(.W(10)) rx_sym ();
  pcs_stream_if #(.W(20)) rx_asm ();
  pcs_stream_if #(.W(20)) rx_out ();

  // Fabric ports onto the streams
  assign tx_fab.valid = tx_valid;
  assign tx_fab.data = tx_data;
  assign tx_ready = tx_fab.ready;
  assign rx_data = rx_out.data;
  assign rx_valid = rx_out.valid;
  assign rx_out.ready = rx_ready;
  assign rx_sym.ready = 1'b1;
  assign rx_asm.valid = asm_v_q;
  assign rx_asm.data = asm_w_q;
  assign rx_over = rx_asm.valid & ~rx_asm.ready;

  // Three-stage sampling of link clock and serial data
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : lvl_q[i];
    end
  end
  assign bit_tick = lvl_d[0] & ~lvl_q[0];
  assign slip_req = rx_bitslip & ~bs_prev_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      s3_q <= 2'h0;
      lvl_q <= 2'h0;
      bs_prev_q <= 1'b0;
    end else begin
      s1_q <= {rx_serial, link_clk};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      bs_prev_q <= rx_bitslip;
    end
  end

  // Transmit phase buffer, one register deep in fixed-latency mode
  two_entry_buffer u_tx_buf (
    .ref_clk(ref_clk),
    .srst(path_rst),
    .one_deep(regm_q),
    .up(tx_fab),
    .dn(tx_word)
  );

  // Receive phase buffer toward the fabric
  two_entry_buffer u_rx_buf (
    .ref_clk(ref_clk),
    .srst(path_rst),
    .one_deep(regm_q),
    .up(rx_asm),
    .dn(rx_out)
  );

  // Ten-bit line shifters
  line_serdes u_serdes (
    .ref_clk(ref_clk),
    .srst(path_rst),
    .bit_tick(bit_tick),
    .rx_bit(lvl_q[1]),
    .slip(slip_req),
    .tx(tx_sym),
    .rx(rx_sym),
    .tx_bit(tx_serial),
    .underrun(underrun)
  );

  // Byte serializer: low half first, word released after the high half
  always_comb begin
    txh_d = txh_q;
    tx_sym.valid = tx_word.valid;
    tx_sym.data = sym_of(tx_word.data, cod, txh_q == HALF_HIGH);
    tx_word.ready = tx_sym.ready & (~dbl | txh_q == HALF_HIGH);
    unique case (txh_q)
      HALF_LOW: begin
        if (dbl && tx_sym.valid && tx_sym.ready) begin
          txh_d = HALF_HIGH;
        end
      end
      HALF_HIGH: begin
        if (tx_sym.valid && tx_sym.ready) begin
          txh_d = HALF_LOW;
        end
      end
    endcase
  end

  // Byte deserializer: first symbol is the low half
  always_comb begin
    rxh_d = rxh_q;
    low_d = low_q;
    asm_v_d = 1'b0;
    asm_w_d = asm_w_q;
    if (rx_sym.valid) begin
      unique case (rxh_q)
        HALF_LOW: begin
          if (dbl) begin
            low_d = rx_sym.data;
            rxh_d = HALF_HIGH;
          end else begin
            asm_v_d = 1'b1;
            asm_w_d = word_of(10'h000, rx_sym.data, cod, 1'b0);
          end
        end
        HALF_HIGH: begin
          asm_v_d = 1'b1;
          asm_w_d = word_of(rx_sym.data, low_q, cod, 1'b1);
          rxh_d = HALF_LOW;
        end
      endcase
    end
  end

  // Byte serdes state
  always_ff @(posedge ref_clk) begin
    if (path_rst) begin
      txh_q <= HALF_LOW;
      rxh_q <= HALF_LOW;
      low_q <= 10'h000;
      asm_v_q <= 1'b0;
      asm_w_q <= 20'h0_0000;
    end else begin
      txh_q <= txh_d;
      rxh_q <= rxh_d;
      low_q <= low_d;
      asm_v_q <= asm_v_d;
      asm_w_q <= asm_w_d;
    end
  end

  // Status word: run, bad setting, stickies, register mode, feedback, slips
  assign status = {16'h0000, slip_q, 2'h0, pll_q, regm_q, over_q, under_q,
                   ctrl_q[`CTRL_ENABLE] & ~cfg_ok(mode, dbl, cod), run_q};

  // APB: read data latched in the first access cycle, write at completion
  assign acc = psel & penable & ~pready_q;
  assign wr_done = psel & penable & pready_q & pwrite & ~perr_q;

  always_comb begin
    ctrl_d = ctrl_q;
    txcnt_d = txcnt_q;
    rxcnt_d = rxcnt_q;
    slip_d = slip_q;
    under_d = under_q;
    over_d = over_q;
    prdata_d = prdata_q;
    perr_d = 1'b0;
    pready_d = acc;
    if (acc) begin
      perr_d = 1'b0;
      case (paddr)
        `OFS_CTRL: prdata_d = {27'h000_0000, ctrl_q};
        `OFS_STATUS: prdata_d = status;
        `OFS_TXCNT: prdata_d = {16'h0000, txcnt_q};
        `OFS_RXCNT: prdata_d = {16'h0000, rxcnt_q};
        default: begin
          prdata_d = 32'h0000_0000;
          perr_d = 1'b1;
        end
      endcase
    end
    if (wr_done && paddr == `OFS_CTRL) begin
      ctrl_d = pwdata[4:0];
    end
    if (wr_done && paddr == `OFS_STATUS) begin
      under_d = under_q & ~pwdata[`ST_UNDER];
      over_d = over_q & ~pwdata[`ST_OVER];
    end
    // Hardware events win over a clear in the same cycle
    if (underrun) begin
      under_d = 1'b1;
    end
    if (rx_over) begin
      over_d = 1'b1;
    end
    if (tx_fab.valid && tx_fab.ready) begin
      txcnt_d = txcnt_q + 16'h0001;
    end
    if (rx_out.valid && rx_out.ready) begin
      rxcnt_d = rxcnt_q + 16'h0001;
    end
    if (slip_req) begin
      slip_d = slip_q + 8'h01;
    end
  end

  // Run, register mode and PLL feedback follow the control word
  always_comb begin
    run_d = ctrl_q[`CTRL_ENABLE] & cfg_ok(mode, dbl, cod);
    regm_d = run_d & (mode == MODE_DETLAT);
    pll_d = regm_q;
  end

  // Register file and bus answer
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q <= `CTRL_RESET;
      txcnt_q <= 16'h0000;
      rxcnt_q <= 16'h0000;
      slip_q <= 8'h00;
      under_q <= 1'b0;
      over_q <= 1'b0;
      run_q <= 1'b0;
      regm_q <= 1'b0;
      pll_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      txcnt_q <= txcnt_d;
      rxcnt_q <= rxcnt_d;
      slip_q <= slip_d;
      under_q <= under_d;
      over_q <= over_d;
      run_q <= run_d;
      regm_q <= regm_d;
      pll_q <= pll_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      perr_q <= perr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = perr_q; // Error flop is high only in the answer cycle
  assign pll_fb_en = pll_q;

  // Checks on the datapath
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  chk_ten_to_one: assert property (
    !dbl && tx_sym.valid && tx_sym.ready |-> tx_word.ready)
    else $error("narrow word not released with its symbol");
  chk_byte_split: assert property (
    run_q && dbl && txh_q == HALF_LOW && tx_sym.valid && tx_sym.ready
    |-> !tx_word.ready ##1 txh_q == HALF_HIGH)
    else $error("wide word released after one symbol");
  chk_raw_symbol: assert property (
    !dbl && !cod && tx_sym.valid |-> tx_sym.data == tx_word.data[9:0])
    else $error("transmit symbol altered");
  chk_rx_single: assert property (
    run_q && !dbl && rx_sym.valid
    |=> asm_v_q && asm_w_q[9:0] == ($past(cod) ?
        {2'h0, $past(rx_sym.data[7:0])} : $past(rx_sym.data)))
    else $error("narrow symbol not passed to buffer");
  chk_rx_pair: assert property (
    run_q && dbl && rx_sym.valid && rxh_q == HALF_LOW |=> !asm_v_q)
    else $error("wide word built from one symbol");
  chk_reg_depth: assert property (
    regm_q && tx_fab.valid && tx_fab.ready |=> !tx_fab.ready)
    else $error("register mode took a second word");
  chk_tx_latency: assert property (
    run_q && tx_fab.valid && tx_fab.ready && !tx_word.valid
    |=> tx_word.valid)
    else $error("transmit buffer latency not one cycle");
  chk_rx_latency: assert property (
    run_q && rx_asm.valid && rx_asm.ready && !rx_out.valid
    |=> rx_out.valid)
    else $error("receive buffer latency not one cycle");
  chk_cfg_halt: assert property (
    !run_q |=> !tx_ready)
    else $error("stopped channel accepts words");
  chk_coded_byte: assert property (
    cod && tx_sym.valid |-> tx_sym.data[9:8] == 2'h0)
    else $error("coded symbol carries raw bits");
  chk_pll_follow: assert property (
    run_q && $past(mode) == MODE_DETLAT |=> pll_fb_en)
    else $error("feedback path off in fixed-latency mode");
  chk_direct_raw: assert property (
    run_q && $past(mode) == MODE_DIRECT |-> $past(dbl) && !$past(cod))
    else $error("direct path running with bad width");

  cov_wide_rx: cover property (rx_out.valid && rx_ready && dbl);
  cov_reg_push: cover property (regm_q && tx_fab.valid && tx_fab.ready);
  cov_slip: cover property (run_q && slip_req);
  cov_rx_over: cover property (rx_over);
endmodule
`default_nettype wire

// File: core/two_entry_buffer.sv
// Two-entry phase buffer, or a single register when one_deep is set
`timescale 1ns/1ns
`default_nettype none
module two_entry_buffer
  import pcs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Register mode
  input wire logic one_deep,
  // Streams
  pcs_stream_if.snk up,
  pcs_stream_if.src dn
);
  logic [19:0] mem_q [0:1];
  logic [19:0] mem_d [0:1];
  logic [1:0] cnt_q, cnt_d;
  logic rdy_q, rdy_d, vld_q, vld_d;
  logic push, pop;

  // Handshakes and registered flags
  assign push = up.valid & rdy_q;
  assign pop = vld_q & dn.ready;
  assign up.ready = rdy_q;
  assign dn.valid = vld_q;
  assign dn.data = mem_q[0];

  // Entry 0 is the head that faces the drain side
  always_comb begin
    cnt_d = cnt_q;
    mem_d[0] = mem_q[0];
    mem_d[1] = mem_q[1];
    case ({push, pop})
      2'b10: begin
        mem_d[cnt_q[0]] = up.data;
        cnt_d = cnt_q + 2'h1;
      end
      2'b01: begin
        mem_d[0] = mem_q[1];
        cnt_d = cnt_q - 2'h1;
      end
      2'b11: begin
        if (cnt_q == 2'h1) begin
          mem_d[0] = up.data;
        end else begin
          mem_d[0] = mem_q[1];
          mem_d[1] = up.data;
        end
      end
      default: begin
      end
    endcase
    vld_d = (cnt_d != 2'h0);
    rdy_d = one_deep ? (cnt_d == 2'h0) : (cnt_d != 2'h2);
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q <= 2'h0;
      rdy_q <= 1'b0;
      vld_q <= 1'b0;
      mem_q[0] <= 20'h0_0000;
      mem_q[1] <= 20'h0_0000;
    end else begin
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      vld_q <= vld_d;
      mem_q[0] <= mem_d[0];
      mem_q[1] <= mem_d[1];
    end
  end
endmodule
`default_nettype wire

// File: verification/remote_line_model.sv
// Remote serial end: line clock in frames, receive bits out, send bits in
`timescale 1ns/1ns
`default_nettype none
module remote_line_model (
  // Line toward the channel
  output logic link_clk,
  output logic rx_serial,
  // Line from the channel
  input wire logic tx_serial
);
  logic rxq[$];
  logic cap[$];

  // Line idle at time zero, clock standing still
  initial begin
    link_clk = 1'b0;
    rx_serial = 1'b0;
  end

  // One frame of whole symbols; bits change on the falling edge
  task automatic frame(input int nsym);
    for (int i = 0; i < nsym * 10; i++) begin
      rx_serial = (rxq.size() > 0) ? rxq.pop_front() : ~rx_serial;
      #40;
      if (i > 0) cap.push_back(tx_serial); // Bit of the previous tick
      link_clk = 1'b1;
      #40;
      link_clk = 1'b0;
    end
    #40;
    cap.push_back(tx_serial);
    rx_serial = ~rx_serial; // Released line shows no stale level
  endtask
endmodule
`default_nettype wire

// File: verification/tb_serial_channel_protocol_datapath.sv
// Bench for the channel datapath: APB setup, fabric words, line checks
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  n_errors++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_serial_channel_protocol_datapath
  import pcs_pkg::*;
();
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic er, tx_valid, tx_ready, rx_valid, rx_ready, rx_bitslip;
  logic link_clk, rx_serial, tx_serial, pll_fb_en;
  word_t tx_data, rx_data;
  word_t rxw[$];
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int ntx = 0;
  int nrx = 0;

  serial_channel_protocol_datapath i_serial_channel_protocol_datapath (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_bitslip(rx_bitslip),
    .link_clk(link_clk), .rx_serial(rx_serial), .tx_serial(tx_serial),
    .pll_fb_en(pll_fb_en));

  remote_line_model i_remote_line_model (
    .link_clk(link_clk), .rx_serial(rx_serial), .tx_serial(tx_serial));

  // Clock
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  // Collect delivered words and cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxw.push_back(rx_data);
    if (cycles == 40000) begin
      n_errors++;
      final_report();
    end
  end

  // Verdict and end of run
  task automatic final_report();
    $display("TB: compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read and compare data and error response
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex,
                        input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("prdata", ex, rd)
    `CHK("pslverr", ee, er)
  endtask

  // Configure, fill the transmit buffer, run a frame, check both ways
  task automatic scen(input logic [4:0] ct, input word_t w0,
                      input word_t w1, input logic stall);
    logic dbl, cod, fix, hit, m;
    int k;
    word_t w, ex;
    sym_t s[$];
    logic eb[$];
    logic c[$];
    dbl = ct[2];
    cod = ct[3];
    fix = (ct[1:0] == 2'h1);
    k = fix ? 1 : 2;
    rxw.delete();
    i_remote_line_model.cap.delete();
    rx_ready <= ~stall;
    apb(1'b1, 12'h000, {27'h000_0000, ct});
    rd_chk(12'h000, {27'h000_0000, ct}, 1'b0);
    `CHK("pll_fb_en", fix, pll_fb_en)
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK("status", {fix, fix, 4'h1}, rd[5:0])
    for (int i = 0; i < 20 && tx_ready !== 1'b1; i++) @(posedge ref_clk);
    for (int i = 0; i < k; i++) begin
      w = (i == 0) ? w0 : w1;
      tx_valid <= 1'b1;
      tx_data <= w;
      do @(posedge ref_clk); while (tx_ready !== 1'b1);
      s.push_back(cod ? {2'h0, w[7:0]} : w[9:0]);
      if (dbl) s.push_back(cod ? {2'h0, w[15:8]} : w[19:10]);
    end
    tx_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("tx_full", 1'b0, tx_ready)
    foreach (s[j]) for (int b = 0; b < 10; b++) eb.push_back(s[j][b]);
    i_remote_line_model.rxq = eb;
    #3;
    i_remote_line_model.frame(8);
    @(posedge ref_clk);
    if (stall) begin
      `CHK("rx_held", 1'b1, rx_valid)
      rx_ready <= 1'b1;
    end
    repeat (40) @(posedge ref_clk);
    if (cod) ex = dbl ? {4'h0, s[1][7:0], s[0][7:0]} : {12'h000, s[0][7:0]};
    else ex = dbl ? {s[1], s[0]} : {10'h000, s[0]};
    `CHK("rx_data", ex, rxw[0])
    c = i_remote_line_model.cap;
    hit = 1'b0;
    for (int p = 0; p + eb.size() <= c.size(); p++) begin
      m = 1'b1;
      foreach (eb[j]) if (c[p + j] !== eb[j]) m = 1'b0;
      if (m) hit = 1'b1;
    end
    `CHK("tx_line", 1'b1, hit)
    ntx += k;
    nrx += stall ? 2 : (dbl ? 4 : 8);
    rd_chk(12'h008, 32'(ntx), 1'b0);
    rd_chk(12'h00C, 32'(nrx), 1'b0);
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK("underrun_overflow", {stall, 1'b1}, rd[3:2])
    apb(1'b1, 12'h004, 32'h0000_000C);
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK("sticky_clear", 2'h0, rd[3:2])
    apb(1'b1, 12'h000, 32'h0000_0000);
    $display("test ctrl %h done", ct);
  endtask

  // Refused settings: error flagged, channel stays stopped
  task automatic bad(input logic [4:0] ct);
    apb(1'b1, 12'h000, {27'h000_0000, ct});
    repeat (6) @(posedge ref_clk);
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK("cfg_error", 2'h2, rd[1:0])
    `CHK("tx_ready_off", 1'b0, tx_ready)
    `CHK("pll_off", 1'b0, pll_fb_en)
    apb(1'b1, 12'h000, 32'h0000_0000);
    $display("test bad ctrl %h done", ct);
  endtask

  // Main sequence
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    tx_data = 20'h0_0000;
    tx_valid = 1'b0;
    rx_ready = 1'b1;
    rx_bitslip = 1'b0;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) rd_chk(12'(i * 4), 32'h0000_0000, 1'b0);
    rd_chk(12'h010, 32'h0000_0000, 1'b1);
    rd_chk(12'h002, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    rd_chk(12'h000, 32'h0000_0000, 1'b0);
    rx_bitslip <= 1'b1;
    @(posedge ref_clk);
    rx_bitslip <= 1'b0;
    rd_chk(12'h004, 32'h0000_0100, 1'b0);
    $display("test registers done");
    scen(5'h10, 20'h0_0235, 20'h0_01C6, 1'b1);
    scen(5'h14, 20'hA_5C3B, 20'h3_96E1, 1'b0);
    scen(5'h19, 20'hF_F2AB, 20'h0_0000, 1'b0);
    scen(5'h11, 20'h0_001F, 20'h0_0000, 1'b0);
    scen(5'h1D, 20'h0_6D4E, 20'h0_0000, 1'b0);
    scen(5'h15, 20'h7_1A93, 20'h0_0000, 1'b0);
    scen(5'h17, 20'hC_3E5A, 20'h5_A0C7, 1'b0);
    bad(5'h18);
    bad(5'h12);
    bad(5'h13);
    final_report();
  end
endmodule
`default_nettype wire
